// ==== core/ivs_vector_select.sv ====
// Purpose: interrupt vector generation and bus address latching
// Assumes: bus pins are asynchronous and pass two flops before use
// Notes:   registered outputs; vector output enable stands while driving
// What this block does
// - Without the extra gate only vectors 0 through octal 374 are produced.
// - With the extra gate vectors up to octal 774 are produced.
// - A strap tied to ground gives a zero vector bit and an open strap a one.
// - Bit 2 may follow the channel B select so B's vector is A's plus four.
// - With that strapping bit 2 is zero while A is master and one while B is.
// - On the asserting edge of bus sync the bus address is caught in four latches.
// - A true-level copy of bus sync is offered to user logic.
// - Bus control lines are received and given to user logic as true levels.
// - With the jumper removed the enable strap sets the vector drive enable.
// - The vector drive enable gates the vector onto the data lines, jumper in or out.
// - Jumper in gives a vector at each interrupt while the normal enable source is high; out and strap grounded gives none.
`timescale 1ns/100ps
module ivs_vector_select
    import ivs_pkg::*;
#(
    parameter int unsigned ADDR_W = IVS_ADDR_W
) (
    input  wire logic              i_sys_clk,                 // system clock
    input  wire logic              i_rst_b,                   // async reset, active low
    input  wire logic              i_ce,                      // clock enable
    input  wire ivs_bus_ctl_t      i_bus_ctl,                 // bus control lines, active low
    input  wire logic [ADDR_W-1:0] i_bus_dal,                 // bus data/address lines
    input  wire logic              i_vector_strobe,           // interrupt logic vector request
    input  wire logic              i_channel_b_vector_select, // channel B is master
    input  wire logic              i_vector_drive_enable,     // normal vector drive enable source
    input  wire ivs_strap_t        i_straps,                  // strap and jumper setting
    output logic [IVS_VEC_W-1:0]   o_vec_data,                // vector onto bus data lines
    output logic                   o_vec_oe,                  // high while vector is driven
    output logic                   o_vector_drive_enable,     // effective enable level
    output ivs_user_ctl_t          o_user_ctl,                // true-level control copies
    output logic                   o_bus_sync_true_level,     // true-level bus sync
    output logic [ADDR_W-1:0]      o_addr_latch [IVS_NUM_LATCH] // four holding latches
);

    // two-flop synchronisers; stage one only feeds stage two
    // every pin is sampled by the same two stages, so a word and its sync
    // line keep their relative timing through the pipeline
    ivs_bus_ctl_t         ctl_s1_q;
    ivs_bus_ctl_t         ctl_s2_q;
    logic [ADDR_W-1:0]    dal_s1_q;
    logic [ADDR_W-1:0]    dal_s2_q;
    logic                 strobe_s1_q;
    logic                 strobe_s2_q;
    logic                 chan_b_s1_q;
    logic                 chan_b_s2_q;
    logic                 enb_src_s1_q;
    logic                 enb_src_s2_q;
    ivs_strap_t           strap_s1_q;
    ivs_strap_t           strap_s2_q;

    // edge detection and vector assembly
    logic                 sync_prev_q;
    logic                 sync_rise;
    logic [IVS_VEC_W-1:0] strap_vec;
    logic                 enb_d;
    logic                 drive_d;
    logic [IVS_VEC_W-1:0] vec_d;

    // bus control lines; every line idles high
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_s1_q <= '1;
            ctl_s2_q <= '1;
        end else if (i_ce) begin
            ctl_s1_q <= i_bus_ctl;
            ctl_s2_q <= ctl_s1_q;
        end
    end

    // bus data/address lines
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dal_s1_q <= '0;
            dal_s2_q <= '0;
        end else if (i_ce) begin
            dal_s1_q <= i_bus_dal;
            dal_s2_q <= dal_s1_q;
        end
    end

    // vector strobe from the interrupt logic
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_s1_q <= 1'h0;
            strobe_s2_q <= 1'h0;
        end else if (i_ce) begin
            strobe_s1_q <= i_vector_strobe;
            strobe_s2_q <= strobe_s1_q;
        end
    end

    // channel B master indication
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chan_b_s1_q <= 1'h0;
            chan_b_s2_q <= 1'h0;
        end else if (i_ce) begin
            chan_b_s1_q <= i_channel_b_vector_select;
            chan_b_s2_q <= chan_b_s1_q;
        end
    end

    // normal source of the vector drive enable
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enb_src_s1_q <= 1'h0;
            enb_src_s2_q <= 1'h0;
        end else if (i_ce) begin
            enb_src_s1_q <= i_vector_drive_enable;
            enb_src_s2_q <= enb_src_s1_q;
        end
    end

    // straps and jumper are static, but are still synchronised in case they move
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_s1_q <= '0;
            strap_s2_q <= '0;
        end else if (i_ce) begin
            strap_s1_q <= i_straps;
            strap_s2_q <= strap_s1_q;
        end
    end

    // each vector bit position has its own source
    for (genvar b = 0; b < IVS_VEC_W; b++) begin : g_vec_bit
        if (b < IVS_STRAP_LO - 1) begin : g_fixed
            assign strap_vec[b] = 1'h0;
        end else if (b == IVS_STRAP_LO - 1) begin : g_chan
            assign strap_vec[b] = strap_s2_q.bit2_from_channel_b ? chan_b_s2_q
                                                                 : strap_s2_q.vector_bit2_strap_point;
        end else if (b < IVS_STRAP_HI_X) begin : g_strap
            assign strap_vec[b] = strap_s2_q.vec_straps_open[b-IVS_STRAP_LO];
        end else if (b == IVS_STRAP_HI_X) begin : g_gated
            assign strap_vec[b] = strap_s2_q.extra_gate & strap_s2_q.vec_straps_open[b-IVS_STRAP_LO];
        end else begin : g_unused
            assign strap_vec[b] = 1'h0;
        end
    end

    // jumper out: the enable strap alone sets the drive enable level
    assign enb_d = strap_s2_q.vector_jumper ? enb_src_s2_q
                                            : strap_s2_q.vector_enable_strap_point;
    assign drive_d = strobe_s2_q & enb_d;
    // vector lines rest at zero so nothing stale reaches the bus between strobes
    assign vec_d = drive_d ? strap_vec : IVS_RST_VEC;

    // true-level control copies
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_user_ctl <= '0;
        end else if (i_ce) begin
            o_user_ctl <= ~ctl_s2_q;
        end
    end

    // true-level copy of bus sync
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_sync_true_level <= 1'h0;
        end else if (i_ce) begin
            o_bus_sync_true_level <= ~ctl_s2_q.sync_l;
        end
    end

    // previous sync level; resets deasserted so no false edge follows reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_prev_q <= 1'h0;
        end else if (i_ce) begin
            sync_prev_q <= ~ctl_s2_q.sync_l;
        end
    end

    assign sync_rise = ~ctl_s2_q.sync_l & ~sync_prev_q;

    // address capture on sync assertion; all four latches take the same word
    for (genvar g = 0; g < IVS_NUM_LATCH; g++) begin : g_latch
        always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                o_addr_latch[g] <= ADDR_W'(IVS_RST_ADDR);
            end else if (i_ce && sync_rise) begin
                o_addr_latch[g] <= dal_s2_q;
            end
        end
    end

    // effective enable level, shown whether or not a vector is requested
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_vector_drive_enable <= 1'h0;
        end else if (i_ce) begin
            o_vector_drive_enable <= enb_d;
        end
    end

    // jumper in: drive at each strobe while the normal enable source is high; jumper out: strap level alone decides
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_vec_oe <= 1'h0;
        end else if (i_ce) begin
            o_vec_oe <= drive_d;
        end
    end

    // vector word onto the data lines
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_vec_data <= IVS_RST_VEC;
        end else if (i_ce) begin
            o_vec_data <= vec_d;
        end
    end

endmodule // ivs_vector_select

// ==== shared/ivs_pkg.sv ====
// Purpose: constants and carriers for the interrupt vector select block
// Assumes: one 100 MHz clock, asynchronous active-low reset
// Notes:   vector bits 15..0 of the bus word, strap bits are 8..3 plus 2
package ivs_pkg;
    localparam int unsigned IVS_VEC_W       = 16;
    localparam int unsigned IVS_STRAP_LO    = 3;
    localparam int unsigned IVS_STRAP_HI_N  = 7;   // highest strap bit as built
    localparam int unsigned IVS_STRAP_HI_X  = 8;   // highest strap bit with the extra gate
    localparam int unsigned IVS_NUM_LATCH   = 4;
    localparam int unsigned IVS_ADDR_W      = 16;
    localparam logic [15:0] IVS_VEC_MAX_N   = 16'h00fc; // octal 374
    localparam logic [15:0] IVS_VEC_MAX_X   = 16'h01fc; // octal 774
    localparam logic [15:0] IVS_RST_VEC     = 16'h0000;
    localparam logic [15:0] IVS_RST_ADDR    = 16'h0000;
    localparam logic [1:0]  IVS_SYNC_STAGES = 2'h2;

    typedef struct packed {
        logic sync_l;      // active-low bus sync line
        logic dout_l;
        logic din_l;
        logic wtbt_l;
        logic bbsy_l;
        logic iaki_l;
        logic dmgi_l;
    } ivs_bus_ctl_t;

    typedef struct packed {
        logic sync_h;
        logic dout_h;
        logic din_h;
        logic wtbt_h;
        logic bbsy_h;
        logic iaki_h;
        logic dmgi_h;
    } ivs_user_ctl_t;

    typedef struct packed {
        logic       vector_jumper;              // 1 = installed
        logic       vector_enable_strap_point;  // 1 = open (pulled up)
        logic       vector_bit2_strap_point;    // 1 = open
        logic       bit2_from_channel_b;        // bit 2 wrapped to channel B select
        logic       extra_gate;                 // 1 = range extended
        logic [5:0] vec_straps_open;            // bits 8..3, 1 = open
    } ivs_strap_t;
endpackage : ivs_pkg

// ==== verification/interrupt_vector_select_bench.sv ====
// Purpose: self-checking bench for the vector select block
// Assumes: inputs held four edges before each compare
// Notes:   seed 63
`timescale 1ns/100ps
module interrupt_vector_select_bench;
    import ivs_pkg::*;
    logic i_sys_clk = 0, i_rst_b = 0, start = 0, strobe = 0, chb = 0, ven = 0, e_en, oe, en, sync_h, sync_l;
    logic ce = 1, f_en, f_oe;
    logic [15:0] addr = 16'h0, dal, vec, e_vec, f_vec;
    logic [5:0] ctl_rest = 6'h3f;
    ivs_strap_t straps = '0;
    ivs_user_ctl_t uctl;
    logic [15:0] lat [IVS_NUM_LATCH];
    int mismatches = 0, samples_checked = 0;
    int q[$];
    always #5 i_sys_clk = ~i_sys_clk;
    ivs_bus_master bm_u (.i_sys_clk, .i_start(start), .i_addr(addr), .o_sync_l(sync_l), .o_dal(dal));
    ivs_vector_select dut_u (.i_sys_clk, .i_rst_b, .i_ce(ce), .i_bus_ctl({sync_l, ctl_rest}), .i_bus_dal(dal),
        .i_vector_strobe(strobe), .i_channel_b_vector_select(chb), .i_vector_drive_enable(ven), .i_straps(straps),
        .o_vec_data(vec), .o_vec_oe(oe), .o_vector_drive_enable(en), .o_user_ctl(uctl),
        .o_bus_sync_true_level(sync_h), .o_addr_latch(lat));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #50000 mismatches++;
        report_and_stop();
    end
    initial begin
        void'($urandom(63));
        repeat (12) @(posedge i_sys_clk);
        #1 i_rst_b = 1;
        for (int t = 0; t < 80; t++) begin
            @(posedge i_sys_clk); #1;
            // every tenth pass freezes the block while its inputs move
            f_oe = strobe & e_en;
            f_vec = f_oe ? e_vec : 16'h0;
            f_en = e_en;
            ce = (t % 10) != 9;
            {strobe, chb, ven, ctl_rest} = 9'($urandom);
            straps = ivs_strap_t'(11'($urandom));
            repeat (4) @(posedge i_sys_clk); #1;
            if (!ce) begin
                chk({15'h0, en}, {15'h0, f_en});
                chk({15'h0, oe}, {15'h0, f_oe});
                chk(vec, f_vec);
                ce = 1;
                repeat (4) @(posedge i_sys_clk); #1;
            end
            e_en = straps.vector_jumper ? ven : straps.vector_enable_strap_point;
            e_vec = {7'h0, straps.extra_gate & straps.vec_straps_open[5], straps.vec_straps_open[4:0],
                straps.bit2_from_channel_b ? chb : straps.vector_bit2_strap_point, 2'h0};
            chk({15'h0, en}, {15'h0, e_en});
            chk({15'h0, oe}, {15'h0, strobe & e_en});
            chk(vec, (strobe & e_en) ? e_vec : 16'h0);
            chk({9'h0, uctl}, {9'h0, ~{sync_l, ctl_rest}});
            chk({15'h0, sync_h}, {15'h0, ~sync_l});
        end
        $display("vector test done");
        for (int t = 0; t < 4; t++) begin
            addr = 16'($urandom);
            q.push_back(int'(addr));
            start = 1;
            @(posedge i_sys_clk); #1 start = 0;
            repeat (7) @(posedge i_sys_clk); #1;
            chk({15'h0, sync_h}, 16'h0001);
            repeat (6) @(posedge i_sys_clk); #1;
            addr = 16'(q.pop_front());
            for (int i = 0; i < IVS_NUM_LATCH; i++) chk(lat[i], addr);
        end
        $display("latch test done");
        report_and_stop();
    end
endmodule // interrupt_vector_select_bench

// ==== verification/ivs_bus_master.sv ====
// Purpose: processor side of one address cycle
// Assumes: address settles three cycles before sync asserts
// Notes:   released address lines show the inverse of the last address
`timescale 1ns/100ps
module ivs_bus_master (
    input  wire logic        i_sys_clk, // clock
    input  wire logic        i_start,   // begin one address cycle
    input  wire logic [15:0] i_addr,    // address to send
    output logic             o_sync_l,  // bus sync, active low
    output logic [15:0]      o_dal      // address lines
);
    int cnt = 0;
    initial o_sync_l = 1'b1;
    initial o_dal = 16'h0;
    always @(posedge i_sys_clk) begin
        if (i_start && cnt == 0) begin
            cnt <= 8;
            o_dal <= i_addr;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            o_sync_l <= !(cnt > 1 && cnt < 7);
            if (cnt == 1) o_dal <= ~o_dal;
        end
    end
endmodule // ivs_bus_master

// ==== verification/ivs_vector_select_props.sv ====
// Purpose: assertions on the vector select ports
// Assumes: three-edge input to output latency; checks rest while i_ce is low
// Notes:   bound to every ivs_vector_select
`timescale 1ns/100ps
module ivs_vector_select_props
    import ivs_pkg::*;
#(parameter int unsigned ADDR_W = IVS_ADDR_W) (
    input wire logic i_sys_clk, i_rst_b, i_ce, i_vector_strobe, i_channel_b_vector_select, i_vector_drive_enable,
    input wire ivs_bus_ctl_t i_bus_ctl,
    input wire logic [ADDR_W-1:0] i_bus_dal,
    input wire ivs_strap_t i_straps,
    input wire logic [IVS_VEC_W-1:0] o_vec_data,
    input wire logic o_vec_oe, o_vector_drive_enable, o_bus_sync_true_level,
    input wire ivs_user_ctl_t o_user_ctl,
    input wire logic [ADDR_W-1:0] o_addr_latch [IVS_NUM_LATCH]
);
    logic [1:0] age_q;  // edges since reset or i_ce low, so $past never sees reset-time inputs
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            age_q <= 2'h0;
        end else if (!i_ce) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    wire ok = age_q == 2'h3;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b || !i_ce);
    sequence sync_taken; ok && $fell(i_bus_ctl.sync_l); endsequence
    sequence latches_hold;
        o_addr_latch[0] == $past(i_bus_dal, 3) && o_addr_latch[1] == $past(i_bus_dal, 3) &&
        o_addr_latch[2] == $past(i_bus_dal, 3) && o_addr_latch[3] == $past(i_bus_dal, 3);
    endsequence
    chk_low_bits_zero: assert property (o_vec_data[1:0] == 2'h0) else $error("low vector bits set");
    chk_range_as_built: assert property (ok && !$past(i_straps.extra_gate, 3) |-> o_vec_data <= IVS_VEC_MAX_N)
        else $error("vector above as-built range");
    chk_range_extended: assert property (o_vec_data <= IVS_VEC_MAX_X && (!(ok && o_vec_oe &&
        $past(i_straps.extra_gate, 3)) || o_vec_data[8] == $past(i_straps.vec_straps_open[5], 3)))
        else $error("vector above wide range");
    chk_strap_bits: assert property (ok && o_vec_oe |-> o_vec_data[7:3] == $past(i_straps.vec_straps_open[4:0], 3))
        else $error("strap bits wrong");
    chk_bit2_channel: assert property (ok && o_vec_oe && $past(i_straps.bit2_from_channel_b, 3) |->
        o_vec_data[2] == $past(i_channel_b_vector_select, 3)) else $error("bit 2 not channel select");
    chk_latch_load: assert property (sync_taken |-> ##3 latches_hold) else $error("address not latched");
    chk_sync_copy: assert property (ok |-> o_bus_sync_true_level == !$past(i_bus_ctl.sync_l, 3))
        else $error("sync copy wrong");
    chk_ctl_copy: assert property (ok |-> o_user_ctl == 7'(~$past(i_bus_ctl, 3))) else $error("control copy wrong");
    chk_enable_src: assert property (ok |-> o_vector_drive_enable == ($past(i_straps.vector_jumper, 3) ?
        $past(i_vector_drive_enable, 3) : $past(i_straps.vector_enable_strap_point, 3))) else $error("enable wrong");
    chk_vector_gate: assert property (ok |-> o_vec_oe == ($past(i_vector_strobe, 3) && o_vector_drive_enable))
        else $error("vector gating wrong");
endmodule // ivs_vector_select_props
bind ivs_vector_select ivs_vector_select_props #(.ADDR_W(ADDR_W)) props_u (.i_sys_clk, .i_rst_b, .i_ce,
    .i_vector_strobe, .i_channel_b_vector_select, .i_vector_drive_enable, .i_bus_ctl, .i_bus_dal, .i_straps,
    .o_vec_data, .o_vec_oe, .o_vector_drive_enable, .o_bus_sync_true_level, .o_user_ctl, .o_addr_latch);
